// ===== hdl/mpx_exec.sv
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Decode sixteen operations; 0000 multiply-and-copy, 0110 nop, 1111 subtract multiplicand.
// - Source and destination select bits pick accumulator zero or one.
// - Multiplicand is sign-extended to 36 bits for every two-operand use.
// - Four flags follow the value the arithmetic unit computes.
// - Single access post-modifies pointer: none, increment, decrement, add first step.
// - Top two pointer-field bits choose one of four RAM pointers.
// - Multiplier input loads from coefficient space at table address, internal or external.
// - Table address then advances by one or by the table step register.
// - Accumulator bits 31..16 copy into the multiplicand during the operation.
// - That copy takes the accumulator value before the concurrent operation.
// - Dual loads with table address take two cycles, one when cached.
// - Second accumulator is always opposite the destination accumulator.
// - Accumulator load writes whole accumulator or low half from pointed RAM.
// - Multiplicand store writes high or low half, then post-modifies pointer.
// - Compound move: save, load, first modify, write saved, second modify.
// - Compound codes: none/+1, +1/none, -1/+2, first step/second step.
// - Compound pointer chosen from top two bits of its field.
// - Compound accumulator move swaps second accumulator or low half with RAM.
module mpx_exec #(
	parameter logic [15:0] X_INT_LIMIT = 16'h1000
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_ext_mem_pin,
	output mpx_pkg::mpx_mem_t o_ymem,
	input wire logic [15:0] i_ymem_rdata,
	output mpx_pkg::mpx_mem_t o_xmem,
	output logic o_x_ext,
	input wire logic [15:0] i_xmem_rdata,
	output logic o_busy
);

	if (X_INT_LIMIT == 16'h0000)
	begin : g_chk
		$error("X_INT_LIMIT must leave some internal coefficient space");
	end

	////////////////////////////////////////////////////////////////////////////
	// Group classification helpers.
	function automatic logic f_legal(input logic [4:0] g);
		f_legal = (g == mpx_pkg::GRP_LD_YX) || (g == mpx_pkg::GRP_A0_YX) ||
			(g == mpx_pkg::GRP_A1_YX) || (g == mpx_pkg::GRP_LD_AT) ||
			(g == mpx_pkg::GRP_ST_Y) || (g == mpx_pkg::GRP_CMP_Y) ||
			(g == mpx_pkg::GRP_CMP_AT);
	endfunction : f_legal

	function automatic logic f_uses_pt(input logic [4:0] g);
		f_uses_pt = (g == mpx_pkg::GRP_LD_YX) || (g == mpx_pkg::GRP_A0_YX) ||
			(g == mpx_pkg::GRP_A1_YX);
	endfunction : f_uses_pt

	function automatic logic f_compound(input logic [4:0] g);
		f_compound = (g == mpx_pkg::GRP_CMP_Y) || (g == mpx_pkg::GRP_CMP_AT);
	endfunction : f_compound

	// First modification; the compound table shares it with single access.
	function automatic logic [15:0] f_pm1(input logic [15:0] r, input logic [1:0] c,
		input logic [15:0] j);
		unique case (c)
			mpx_pkg::PM_NONE: f_pm1 = r;
			mpx_pkg::PM_INC: f_pm1 = r + mpx_pkg::ONE16;
			mpx_pkg::PM_DEC: f_pm1 = r - mpx_pkg::ONE16;
			mpx_pkg::PM_STEP: f_pm1 = r + j;
		endcase
	endfunction : f_pm1

	function automatic logic [15:0] f_pm2(input logic [15:0] r, input logic [1:0] c,
		input logic [15:0] k);
		unique case (c)
			mpx_pkg::PM_NONE: f_pm2 = r + mpx_pkg::ONE16;
			mpx_pkg::PM_INC: f_pm2 = r;
			mpx_pkg::PM_DEC: f_pm2 = r + mpx_pkg::TWO16;
			mpx_pkg::PM_STEP: f_pm2 = r + k;
		endcase
	endfunction : f_pm2

	////////////////////////////////////////////////////////////////////////////
	logic [35:0] acc_ff [0:1];
	logic [15:0] ptr_ff [0:3];
	logic [15:0] x_ff, j_ff, k_ff, pt_ff, i_ff, temp_ff, instr_ff;
	logic [31:0] y_ff, p_ff, prdata_ff, rd_val;
	logic pready_ff, pslverr_ff, ill_ff, cache_ff, x_ext_ff, rd_hit;
	mpx_pkg::mpx_flags_t flags_ff, dau_flags;
	mpx_pkg::mpx_mem_t ymem_ff, xmem_ff;
	mpx_pkg::mpx_state_t state_ff;
	logic [15:0] cur, at_half, y_half;
	logic [4:0] grp;
	logic [35:0] dau_res, at_full;
	logic [31:0] dau_prod;
	logic dau_wr, dau_upd, dau_ldp, busy, apb_wr, wr_ok, iss, x_go, mem1, at_idx;
	logic [1:0] rsel, pmc;

	assign busy = (state_ff != mpx_pkg::ST_IDLE);
	assign mem1 = (state_ff == mpx_pkg::ST_MEM1);

	// Fields come from the write data at issue and from the latch later.
	assign cur = busy ? instr_ff : i_pwdata[15:0];
	assign grp = cur[15:11];
	assign rsel = cur[3:2];
	assign pmc = cur[1:0];
	assign at_idx = !cur[mpx_pkg::B_D];
	assign at_full = {{4{i_ymem_rdata[15]}}, i_ymem_rdata, mpx_pkg::W16_RST};
	assign at_half = cur[mpx_pkg::B_X] ? acc_ff[at_idx][31:16] : acc_ff[at_idx][15:0];
	assign y_half = cur[mpx_pkg::B_X] ? y_ff[31:16] : y_ff[15:0];

	// Writes are refused while an instruction is in flight.
	assign apb_wr = i_psel && i_penable && i_pwrite && pready_ff && !pslverr_ff;
	assign wr_ok = apb_wr && !busy;
	assign iss = wr_ok && (i_paddr == mpx_pkg::OFS_INSTR) && f_legal(grp);
	// cached dual load reads coefficient space at once
	assign x_go = f_uses_pt(grp) && ((iss && cache_ff) || (mem1 && !cache_ff));

	mpx_dau u_dau (
		.i_op(cur[8:5]),
		.i_acc_s(acc_ff[cur[mpx_pkg::B_S]]),
		.i_p(p_ff),
		.i_x(x_ff),
		.i_y(y_ff),
		.o_res(dau_res),
		.o_wr_acc(dau_wr),
		.o_upd_flags(dau_upd),
		.o_ld_p(dau_ldp),
		.o_prod(dau_prod),
		.o_flags(dau_flags)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read mux; an unmapped address answers zero with an error.
	always_comb
	begin
		rd_hit = 1'b1;
		unique case (i_paddr)
			mpx_pkg::OFS_INSTR: rd_val = {16'h0000, instr_ff};
			mpx_pkg::OFS_STATUS: rd_val = {26'h000_0000, flags_ff, ill_ff, busy};
			mpx_pkg::OFS_CFG: rd_val = {31'h0000_0000, cache_ff};
			mpx_pkg::OFS_ACC0L: rd_val = acc_ff[0][31:0];
			mpx_pkg::OFS_ACC0H: rd_val = {28'h000_0000, acc_ff[0][35:32]};
			mpx_pkg::OFS_ACC1L: rd_val = acc_ff[1][31:0];
			mpx_pkg::OFS_ACC1H: rd_val = {28'h000_0000, acc_ff[1][35:32]};
			mpx_pkg::OFS_X: rd_val = {16'h0000, x_ff};
			mpx_pkg::OFS_Y: rd_val = y_ff;
			mpx_pkg::OFS_P: rd_val = p_ff;
			mpx_pkg::OFS_PTR0: rd_val = {16'h0000, ptr_ff[0]};
			mpx_pkg::OFS_PTR1: rd_val = {16'h0000, ptr_ff[1]};
			mpx_pkg::OFS_PTR2: rd_val = {16'h0000, ptr_ff[2]};
			mpx_pkg::OFS_PTR3: rd_val = {16'h0000, ptr_ff[3]};
			mpx_pkg::OFS_J: rd_val = {16'h0000, j_ff};
			mpx_pkg::OFS_K: rd_val = {16'h0000, k_ff};
			mpx_pkg::OFS_PT: rd_val = {16'h0000, pt_ff};
			mpx_pkg::OFS_I: rd_val = {16'h0000, i_ff};
			default:
			begin
				rd_val = mpx_pkg::W32_RST;
				rd_hit = 1'b0;
			end
		endcase
	end

	// APB answer: one access cycle, no wait states.
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= mpx_pkg::W32_RST;
		end
		else
		begin
			pready_ff <= i_psel && !i_penable;
			pslverr_ff <= i_psel && !i_penable && (!rd_hit || (i_pwrite && busy));
			prdata_ff <= (i_psel && !i_penable && !i_pwrite) ? rd_val : mpx_pkg::W32_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Datapath registers: arithmetic at issue, memory captures after.
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			acc_ff[0] <= mpx_pkg::ACC_RST;
			acc_ff[1] <= mpx_pkg::ACC_RST;
			x_ff <= mpx_pkg::W16_RST;
			y_ff <= mpx_pkg::W32_RST;
			p_ff <= mpx_pkg::W32_RST;
			temp_ff <= mpx_pkg::W16_RST;
			flags_ff <= '0;
		end
		else if (iss)
		begin
			if (dau_wr)
				acc_ff[cur[mpx_pkg::B_D]] <= dau_res;
			if (dau_upd)
				flags_ff <= dau_flags;
			if (dau_ldp)
				p_ff <= dau_prod;
			if (grp == mpx_pkg::GRP_A0_YX || grp == mpx_pkg::GRP_A1_YX)
				y_ff[31:16] <= acc_ff[cur[mpx_pkg::B_ACC]][31:16];
			temp_ff <= (grp == mpx_pkg::GRP_CMP_AT) ? at_half : y_half;
		end
		else if (busy)
		begin
			if (xmem_ff.req)
				x_ff <= i_xmem_rdata;
			if (mem1 && ymem_ff.req && !ymem_ff.we)
			begin
				if (grp == mpx_pkg::GRP_LD_AT || grp == mpx_pkg::GRP_CMP_AT)
				begin
					if (cur[mpx_pkg::B_X])
						acc_ff[at_idx] <= at_full;
					else
						acc_ff[at_idx][15:0] <= i_ymem_rdata;
				end
				else if (grp == mpx_pkg::GRP_LD_YX || cur[mpx_pkg::B_X])
					y_ff[31:16] <= i_ymem_rdata;
				else
					y_ff[15:0] <= i_ymem_rdata;
			end
		end
		else if (wr_ok)
		begin
			unique case (i_paddr)
				mpx_pkg::OFS_ACC0L: acc_ff[0][31:0] <= i_pwdata;
				mpx_pkg::OFS_ACC0H: acc_ff[0][35:32] <= i_pwdata[3:0];
				mpx_pkg::OFS_ACC1L: acc_ff[1][31:0] <= i_pwdata;
				mpx_pkg::OFS_ACC1H: acc_ff[1][35:32] <= i_pwdata[3:0];
				mpx_pkg::OFS_X: x_ff <= i_pwdata[15:0];
				mpx_pkg::OFS_Y: y_ff <= i_pwdata;
				mpx_pkg::OFS_P: p_ff <= i_pwdata;
				default: x_ff <= x_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pointers: first modification at issue, second one cycle later.
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			for (int n = 0; n < 4; n++)
				ptr_ff[n] <= mpx_pkg::W16_RST;
			j_ff <= mpx_pkg::W16_RST;
			k_ff <= mpx_pkg::W16_RST;
			pt_ff <= mpx_pkg::W16_RST;
			i_ff <= mpx_pkg::W16_RST;
		end
		else
		begin
			if (iss && !f_uses_pt(grp) || iss && grp == mpx_pkg::GRP_LD_YX)
				ptr_ff[rsel] <= f_pm1(ptr_ff[rsel], pmc, j_ff);
			else if (mem1 && f_compound(grp))
				ptr_ff[rsel] <= f_pm2(ptr_ff[rsel], pmc, k_ff);
			if (x_go)
				pt_ff <= pt_ff + (cur[mpx_pkg::B_X] ? i_ff : mpx_pkg::ONE16);
			if (wr_ok)
			begin
				for (int n = 0; n < 4; n++)
					if (i_paddr == mpx_pkg::OFS_PTR0 + 8'(4 * n))
						ptr_ff[n] <= i_pwdata[15:0];
				if (i_paddr == mpx_pkg::OFS_J)
					j_ff <= i_pwdata[15:0];
				if (i_paddr == mpx_pkg::OFS_K)
					k_ff <= i_pwdata[15:0];
				if (i_paddr == mpx_pkg::OFS_PT)
					pt_ff <= i_pwdata[15:0];
				if (i_paddr == mpx_pkg::OFS_I)
					i_ff <= i_pwdata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer and memory ports. Reads are combinational on the port and
	// are captured at the end of the cycle in which the request stands.
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			state_ff <= mpx_pkg::ST_IDLE;
			instr_ff <= mpx_pkg::W16_RST;
			ymem_ff <= '0;
			xmem_ff <= '0;
			x_ext_ff <= 1'b0;
			ill_ff <= 1'b0;
			cache_ff <= 1'b0;
		end
		else
		begin
			if (x_go)
			begin
				xmem_ff <= '{req: 1'b1, we: 1'b0, addr: pt_ff, wdata: mpx_pkg::W16_RST};
				x_ext_ff <= (pt_ff >= X_INT_LIMIT) || i_ext_mem_pin;
			end
			else
				xmem_ff <= '0;
			unique case (state_ff)
				mpx_pkg::ST_IDLE:
				begin
					if (iss)
					begin
						instr_ff <= i_pwdata[15:0];
						state_ff <= mpx_pkg::ST_MEM1;
						ill_ff <= 1'b0;
						ymem_ff <= '{req: !f_uses_pt(grp) || grp == mpx_pkg::GRP_LD_YX,
							we: grp == mpx_pkg::GRP_ST_Y, addr: ptr_ff[rsel], wdata: y_half};
					end
					else if (wr_ok && i_paddr == mpx_pkg::OFS_INSTR)
						ill_ff <= 1'b1;
					else if (wr_ok && i_paddr == mpx_pkg::OFS_CFG)
						cache_ff <= i_pwdata[0];
				end
				mpx_pkg::ST_MEM1:
				begin
					if (f_compound(grp))
						ymem_ff <= '{req: 1'b1, we: 1'b1, addr: ptr_ff[rsel], wdata: temp_ff};
					else
						ymem_ff <= '0;
					if (f_compound(grp) || (f_uses_pt(grp) && !cache_ff))
						state_ff <= mpx_pkg::ST_MEM2;
					else
						state_ff <= mpx_pkg::ST_IDLE;
				end
				mpx_pkg::ST_MEM2:
				begin
					ymem_ff <= '0;
					state_ff <= mpx_pkg::ST_IDLE;
				end
				default: state_ff <= mpx_pkg::ST_IDLE;
			endcase
		end
	end

	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_ymem = ymem_ff;
	assign o_xmem = xmem_ff;
	assign o_x_ext = x_ext_ff;
	assign o_busy = busy;

	////////////////////////////////////////////////////////////////////////////
	// Checks beside the logic they guard.
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	property p_nop;
		iss && cur[8:5] == mpx_pkg::F1_NOP |=> $stable(flags_ff) && $stable(p_ff);
	endproperty
	a_nop: assert property (p_nop) else $error("nop changed state");

	property p_ld_y;
		iss && cur[8:5] == mpx_pkg::F1_LD_Y |=>
			acc_ff[instr_ff[mpx_pkg::B_D]] == {{4{$past(y_ff[31])}}, $past(y_ff)};
	endproperty
	a_ld_y: assert property (p_ld_y) else $error("sign-extended load wrong");

	property p_flags;
		iss && dau_upd ##1 1'b1 |-> flags_ff == $past(dau_flags);
	endproperty
	a_flags: assert property (p_flags) else $error("flags not updated");

	property p_inc;
		iss && grp == mpx_pkg::GRP_ST_Y && pmc == mpx_pkg::PM_INC |=>
			ptr_ff[instr_ff[3:2]] == $past(ptr_ff[rsel]) + mpx_pkg::ONE16;
	endproperty
	a_inc: assert property (p_inc) else $error("pointer not incremented");

	property p_store;
		iss && grp == mpx_pkg::GRP_ST_Y |=> o_ymem.req && o_ymem.we &&
			o_ymem.addr == $past(ptr_ff[rsel]) && o_ymem.wdata == $past(y_half);
	endproperty
	a_store: assert property (p_store) else $error("store request wrong");

	property p_pt;
		x_go |=> pt_ff == $past(pt_ff) + ($past(cur[mpx_pkg::B_X]) ? i_ff : mpx_pkg::ONE16);
	endproperty
	a_pt: assert property (p_pt) else $error("table address step wrong");

	property p_copy;
		iss && (grp == mpx_pkg::GRP_A0_YX || grp == mpx_pkg::GRP_A1_YX) |=>
			y_ff[31:16] == $past(acc_ff[cur[mpx_pkg::B_ACC]][31:16]);
	endproperty
	a_copy: assert property (p_copy) else $error("accumulator copy wrong");

	property p_dual;
		iss && grp == mpx_pkg::GRP_LD_YX && !cache_ff |=> busy [*2] ##1 !busy;
	endproperty
	a_dual: assert property (p_dual) else $error("dual load length wrong");

	property p_cmp;
		iss && grp == mpx_pkg::GRP_CMP_Y && pmc == mpx_pkg::PM_DEC |-> ##2
			o_ymem.we && o_ymem.addr == $past(ptr_ff[rsel], 2) - mpx_pkg::ONE16 ##1
			ptr_ff[instr_ff[3:2]] == $past(o_ymem.addr) + mpx_pkg::TWO16;
	endproperty
	a_cmp: assert property (p_cmp) else $error("compound sequence wrong");

endmodule : mpx_exec
`default_nettype wire

// ===== hdl/mpx_pkg.sv
package mpx_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Datapath widths and instruction field positions.
	localparam int ACC_W = 36;
	localparam int DW = 16;
	localparam int B_ACC = 12;
	localparam int B_D = 10;
	localparam int B_S = 9;
	localparam int B_F1 = 5;
	localparam int B_X = 4;

	// Arithmetic operation codes of the four-bit operation field.
	localparam logic [3:0] F1_MPY_P = 4'h0;
	localparam logic [3:0] F1_ADD_P_MPY = 4'h1;
	localparam logic [3:0] F1_MPY = 4'h2;
	localparam logic [3:0] F1_SUB_P_MPY = 4'h3;
	localparam logic [3:0] F1_LD_P = 4'h4;
	localparam logic [3:0] F1_ADD_P = 4'h5;
	localparam logic [3:0] F1_NOP = 4'h6;
	localparam logic [3:0] F1_SUB_P = 4'h7;
	localparam logic [3:0] F1_OR_Y = 4'h8;
	localparam logic [3:0] F1_XOR_Y = 4'h9;
	localparam logic [3:0] F1_TST_AND_Y = 4'hA;
	localparam logic [3:0] F1_CMP_Y = 4'hB;
	localparam logic [3:0] F1_LD_Y = 4'hC;
	localparam logic [3:0] F1_ADD_Y = 4'hD;
	localparam logic [3:0] F1_AND_Y = 4'hE;
	localparam logic [3:0] F1_SUB_Y = 4'hF;

	// Opcode groups held in instruction bits 15 to 11.
	localparam logic [4:0] GRP_LD_YX = 5'h1F;
	localparam logic [4:0] GRP_A0_YX = 5'h19;
	localparam logic [4:0] GRP_A1_YX = 5'h1B;
	localparam logic [4:0] GRP_LD_AT = 5'h07;
	localparam logic [4:0] GRP_ST_Y = 5'h14;
	localparam logic [4:0] GRP_CMP_Y = 5'h15;
	localparam logic [4:0] GRP_CMP_AT = 5'h05;

	// Pointer post-modification codes.
	localparam logic [1:0] PM_NONE = 2'h0;
	localparam logic [1:0] PM_INC = 2'h1;
	localparam logic [1:0] PM_DEC = 2'h2;
	localparam logic [1:0] PM_STEP = 2'h3;

	// Register byte offsets on the APB.
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CFG = 8'h08;
	localparam logic [7:0] OFS_ACC0L = 8'h0C;
	localparam logic [7:0] OFS_ACC0H = 8'h10;
	localparam logic [7:0] OFS_ACC1L = 8'h14;
	localparam logic [7:0] OFS_ACC1H = 8'h18;
	localparam logic [7:0] OFS_X = 8'h1C;
	localparam logic [7:0] OFS_Y = 8'h20;
	localparam logic [7:0] OFS_P = 8'h24;
	localparam logic [7:0] OFS_PTR0 = 8'h28;
	localparam logic [7:0] OFS_PTR1 = 8'h2C;
	localparam logic [7:0] OFS_PTR2 = 8'h30;
	localparam logic [7:0] OFS_PTR3 = 8'h34;
	localparam logic [7:0] OFS_J = 8'h38;
	localparam logic [7:0] OFS_K = 8'h3C;
	localparam logic [7:0] OFS_PT = 8'h40;
	localparam logic [7:0] OFS_I = 8'h44;

	// Reset values and pointer step constants.
	localparam logic [ACC_W-1:0] ACC_RST = 36'h0_0000_0000;
	localparam logic [31:0] W32_RST = 32'h0000_0000;
	localparam logic [DW-1:0] W16_RST = 16'h0000;
	localparam logic [DW-1:0] ONE16 = 16'h0001;
	localparam logic [DW-1:0] TWO16 = 16'h0002;

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {ST_IDLE, ST_MEM1, ST_MEM2} mpx_state_t;
	typedef enum logic [2:0] {K_PASS, K_ADD, K_SUB, K_OR, K_XOR, K_AND} mpx_kind_t;

	// One memory port request.
	typedef struct packed {
		logic req;
		logic we;
		logic [DW-1:0] addr;
		logic [DW-1:0] wdata;
	} mpx_mem_t;

	// Condition flags.
	typedef struct packed {
		logic neg;
		logic eq;
		logic lov;
		logic mov;
	} mpx_flags_t;

	// Decoded control of the arithmetic unit.
	typedef struct packed {
		mpx_kind_t kind;
		logic use_y;
		logic wr;
		logic upd;
		logic ldp;
	} mpx_dctl_t;

endpackage : mpx_pkg

// ===== hdl/mpx_dau.sv
`timescale 1ns/10ps
`default_nettype none

module mpx_dau (
	input wire logic [3:0] i_op,
	input wire logic [35:0] i_acc_s,
	input wire logic [31:0] i_p,
	input wire logic [15:0] i_x,
	input wire logic [31:0] i_y,
	output logic [35:0] o_res,
	output logic o_wr_acc,
	output logic o_upd_flags,
	output logic o_ld_p,
	output logic [31:0] o_prod,
	output mpx_pkg::mpx_flags_t o_flags
);

	logic [35:0] ysx;
	logic [35:0] psx;
	logic [35:0] opb;
	logic [36:0] sum;
	mpx_pkg::mpx_dctl_t ctl;

	////////////////////////////////////////////////////////////////////////////
	// The multiplicand even feeds logic ops sign-extended.
	// multiplicand sign extension
	assign ysx = {{4{i_y[31]}}, i_y};
	assign psx = {{4{i_p[31]}}, i_p};
	assign o_prod = 32'($signed(i_x) * $signed(i_y[31:16]));

	// Operation decode: kind, operand, write, flag update, product load.
	// operation field decode
	always_comb
	begin
		unique case (i_op)
			mpx_pkg::F1_MPY_P: ctl = '{mpx_pkg::K_PASS, 1'b0, 1'b1, 1'b1, 1'b1};
			mpx_pkg::F1_ADD_P_MPY: ctl = '{mpx_pkg::K_ADD, 1'b0, 1'b1, 1'b1, 1'b1};
			mpx_pkg::F1_MPY: ctl = '{mpx_pkg::K_PASS, 1'b0, 1'b0, 1'b0, 1'b1};
			mpx_pkg::F1_SUB_P_MPY: ctl = '{mpx_pkg::K_SUB, 1'b0, 1'b1, 1'b1, 1'b1};
			mpx_pkg::F1_LD_P: ctl = '{mpx_pkg::K_PASS, 1'b0, 1'b1, 1'b1, 1'b0};
			mpx_pkg::F1_ADD_P: ctl = '{mpx_pkg::K_ADD, 1'b0, 1'b1, 1'b1, 1'b0};
			mpx_pkg::F1_NOP: ctl = '{mpx_pkg::K_PASS, 1'b0, 1'b0, 1'b0, 1'b0};
			mpx_pkg::F1_SUB_P: ctl = '{mpx_pkg::K_SUB, 1'b0, 1'b1, 1'b1, 1'b0};
			mpx_pkg::F1_OR_Y: ctl = '{mpx_pkg::K_OR, 1'b1, 1'b1, 1'b1, 1'b0};
			mpx_pkg::F1_XOR_Y: ctl = '{mpx_pkg::K_XOR, 1'b1, 1'b1, 1'b1, 1'b0};
			mpx_pkg::F1_TST_AND_Y: ctl = '{mpx_pkg::K_AND, 1'b1, 1'b0, 1'b1, 1'b0};
			mpx_pkg::F1_CMP_Y: ctl = '{mpx_pkg::K_SUB, 1'b1, 1'b0, 1'b1, 1'b0};
			mpx_pkg::F1_LD_Y: ctl = '{mpx_pkg::K_PASS, 1'b1, 1'b1, 1'b1, 1'b0};
			mpx_pkg::F1_ADD_Y: ctl = '{mpx_pkg::K_ADD, 1'b1, 1'b1, 1'b1, 1'b0};
			mpx_pkg::F1_AND_Y: ctl = '{mpx_pkg::K_AND, 1'b1, 1'b1, 1'b1, 1'b0};
			mpx_pkg::F1_SUB_Y: ctl = '{mpx_pkg::K_SUB, 1'b1, 1'b1, 1'b1, 1'b0};
		endcase
	end

	// Result and flags, with a 37-bit sum to see the 36-bit overflow.
	// flags from result
	always_comb
	begin
		opb = ctl.use_y ? ysx : psx;
		if (ctl.kind == mpx_pkg::K_SUB)
			sum = {i_acc_s[35], i_acc_s} - {opb[35], opb};
		else
			sum = {i_acc_s[35], i_acc_s} + {opb[35], opb};
		unique case (ctl.kind)
			mpx_pkg::K_PASS: o_res = opb;
			mpx_pkg::K_ADD: o_res = sum[35:0];
			mpx_pkg::K_SUB: o_res = sum[35:0];
			mpx_pkg::K_OR: o_res = i_acc_s | opb;
			mpx_pkg::K_XOR: o_res = i_acc_s ^ opb;
			mpx_pkg::K_AND: o_res = i_acc_s & opb;
			default: o_res = opb;
		endcase
		o_flags.neg = o_res[35];
		o_flags.eq = (o_res == mpx_pkg::ACC_RST);
		o_flags.lov = (ctl.kind == mpx_pkg::K_ADD || ctl.kind == mpx_pkg::K_SUB) &&
			(sum[36] ^ sum[35]);
		o_flags.mov = !((&o_res[35:31]) || !(|o_res[35:31]));
		o_wr_acc = ctl.wr;
		o_upd_flags = ctl.upd;
		o_ld_p = ctl.ldp;
	end

endmodule : mpx_dau
`default_nettype wire

// ===== verif/mpx_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Data and coefficient memory; a read answers within its request cycle.
module mpx_mem_model (
	input wire logic i_clk,
	input wire mpx_pkg::mpx_mem_t i_y,
	output logic [15:0] o_y_rd,
	input wire mpx_pkg::mpx_mem_t i_x,
	output logic [15:0] o_x_rd
);
	logic [15:0] ymem [256];
	logic [15:0] xmem [256];
	logic [15:0] ylast_ff = 16'h0000;
	logic [15:0] xlast_ff = 16'h0000;
	// Idle read lines flip every cycle, so a capture one cycle late sees inverted data.
	assign o_y_rd = (i_y.req && !i_y.we) ? ymem[i_y.addr[7:0]] : ~ylast_ff;
	assign o_x_rd = i_x.req ? xmem[i_x.addr[7:0]] : ~xlast_ff;
	// A write lands at the edge that ends its request cycle.
	always @(posedge i_clk)
	begin
		if (i_y.req && i_y.we)
			ymem[i_y.addr[7:0]] <= i_y.wdata;
		ylast_ff <= o_y_rd;
		xlast_ff <= o_x_rd;
	end
endmodule : mpx_mem_model
`default_nettype wire

// ===== verif/mac_parallel_move_exec_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module mac_parallel_move_exec_tb_top;
	logic i_clk = 0, i_rstn = 0, psel = 0, pen = 0, pwr = 0, ext_pin = 0, er, x_ext;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, busy;
	logic [15:0] yrd, xrd;
	mpx_pkg::mpx_mem_t ym, xm;
	int bad_count = 0, comparisons = 0, cyc = 0, nbusy;
	always #5 i_clk = ~i_clk;
	mpx_exec u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_ext_mem_pin(ext_pin), .o_ymem(ym),
		.i_ymem_rdata(yrd), .o_xmem(xm), .o_x_ext(x_ext), .i_xmem_rdata(xrd), .o_busy(busy));
	mpx_mem_model u_mem (.i_clk(i_clk), .i_y(ym), .o_y_rd(yrd), .i_x(xm), .o_x_rd(xrd));
	////////////////////////////////////////
	task end_sim();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// A hung handshake ends the run as a mismatch.
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			end_sim();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Request is held until pready is sampled high; only then released.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask : rdc
	task idle();
		nbusy = 0;
		do
		begin
			@(posedge i_clk);
			nbusy += (busy === 1'b1);
		end while (busy !== 1'b0);
	endtask : idle
	task run(input logic [4:0] g, input logic d, input logic [3:0] f, input logic x,
		input logic [3:0] y);
		apb(1'b1, mpx_pkg::OFS_INSTR, {16'h0000, g, d, 1'b0, f, x, y});
		idle();
	endtask : run
	////////////////////////////////////////
	task t_reset();
		rdc(mpx_pkg::OFS_ACC1L, 32'h0000_0000);
		rdc(8'h48, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
	endtask : t_reset
	task t_sub();
		apb(1'b1, mpx_pkg::OFS_Y, 32'h8000_0000);
		run(mpx_pkg::GRP_ST_Y, 1'b1, mpx_pkg::F1_SUB_Y, 1'b1, 4'h5);
		rdc(mpx_pkg::OFS_PTR1, 32'h0000_0001);
		rdc(mpx_pkg::OFS_ACC1L, 32'h8000_0000);
		rdc(mpx_pkg::OFS_ACC1H, 32'h0000_0000);
		rdc(mpx_pkg::OFS_STATUS, 32'h0000_0004);
		chk(u_mem.ymem[0], 32'h0000_8000);
		run(mpx_pkg::GRP_ST_Y, 1'b0, mpx_pkg::F1_NOP, 1'b1, 4'h4);
		rdc(mpx_pkg::OFS_STATUS, 32'h0000_0004);
	endtask : t_sub
	task t_store();
		apb(1'b1, mpx_pkg::OFS_PTR3, 32'h0000_0010);
		apb(1'b1, mpx_pkg::OFS_J, 32'h0000_0003);
		apb(1'b1, mpx_pkg::OFS_Y, 32'h1234_5678);
		run(mpx_pkg::GRP_ST_Y, 1'b0, mpx_pkg::F1_NOP, 1'b0, 4'hF);
		chk(u_mem.ymem[8'h10], 32'h0000_5678);
		rdc(mpx_pkg::OFS_PTR3, 32'h0000_0013);
	endtask : t_store
	task t_ldacc();
		u_mem.ymem[8'h13] = 16'h8001;
		run(mpx_pkg::GRP_LD_AT, 1'b0, mpx_pkg::F1_NOP, 1'b1, 4'hD);
		rdc(mpx_pkg::OFS_ACC1L, 32'h8001_0000);
		rdc(mpx_pkg::OFS_ACC1H, 32'h0000_000F);
		rdc(mpx_pkg::OFS_PTR3, 32'h0000_0014);
	endtask : t_ldacc
	task t_dual();
		u_mem.xmem[8'h20] = 16'h00AB;
		u_mem.xmem[8'h25] = 16'h0C0D;
		apb(1'b1, mpx_pkg::OFS_ACC0L, 32'h7777_0000);
		apb(1'b1, mpx_pkg::OFS_Y, 32'h0001_0000);
		apb(1'b1, mpx_pkg::OFS_PT, 32'h0000_0020);
		apb(1'b1, mpx_pkg::OFS_I, 32'h0000_0005);
		apb(1'b1, mpx_pkg::OFS_CFG, 32'h0000_0001);
		run(mpx_pkg::GRP_A0_YX, 1'b0, mpx_pkg::F1_LD_Y, 1'b1, 4'h0);
		chk(nbusy, 32'h0000_0001);
		chk({31'h0, x_ext}, 32'h0000_0000);
		rdc(mpx_pkg::OFS_ACC0L, 32'h0001_0000);
		apb(1'b0, mpx_pkg::OFS_Y, 32'h0000_0000);
		chk(rd & 32'hFFFF_0000, 32'h7777_0000);
		rdc(mpx_pkg::OFS_X, 32'h0000_00AB);
		rdc(mpx_pkg::OFS_PT, 32'h0000_0025);
		apb(1'b1, mpx_pkg::OFS_CFG, 32'h0000_0000);
		run(mpx_pkg::GRP_LD_YX, 1'b0, mpx_pkg::F1_NOP, 1'b0, 4'h1);
		chk(nbusy, 32'h0000_0002);
		rdc(mpx_pkg::OFS_X, 32'h0000_0C0D);
		rdc(mpx_pkg::OFS_PT, 32'h0000_0026);
		// The pin alone forces the coefficient read external.
		ext_pin <= 1'b1;
		u_mem.xmem[8'h26] = 16'h0042;
		run(mpx_pkg::GRP_A1_YX, 1'b0, mpx_pkg::F1_NOP, 1'b0, 4'h0);
		ext_pin <= 1'b0;
		chk({31'h0, x_ext}, 32'h0000_0001);
		apb(1'b0, mpx_pkg::OFS_Y, 32'h0000_0000);
		chk(rd & 32'hFFFF_0000, 32'h8001_0000);
	endtask : t_dual
	task t_swap();
		u_mem.ymem[8'h40] = 16'h5555;
		apb(1'b1, mpx_pkg::OFS_PTR2, 32'h0000_0040);
		apb(1'b1, mpx_pkg::OFS_Y, 32'hAAAA_0000);
		apb(1'b1, mpx_pkg::OFS_INSTR, {16'h0000, mpx_pkg::GRP_CMP_Y, 2'b00, mpx_pkg::F1_NOP,
			1'b1, 4'hA});
		apb(1'b1, mpx_pkg::OFS_INSTR, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
		idle();
		chk(u_mem.ymem[8'h3F], 32'h0000_AAAA);
		rdc(mpx_pkg::OFS_PTR2, 32'h0000_0041);
		apb(1'b0, mpx_pkg::OFS_Y, 32'h0000_0000);
		chk(rd & 32'hFFFF_0000, 32'h5555_0000);
		// Accumulator swap: old upper half of acc0 goes out, memory comes in.
		u_mem.ymem[8'h41] = 16'h1357;
		run(mpx_pkg::GRP_CMP_AT, 1'b1, mpx_pkg::F1_NOP, 1'b1, 4'h8);
		rdc(mpx_pkg::OFS_ACC0L, 32'h1357_0000);
		chk(u_mem.ymem[8'h41], 32'h0000_0001);
		rdc(mpx_pkg::OFS_PTR2, 32'h0000_0042);
	endtask : t_swap
	// Reset for ten cycles, then the scenarios in turn.
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		t_reset();
		t_sub();
		t_store();
		t_ldacc();
		t_dual();
		t_swap();
		end_sim();
	end
endmodule : mac_parallel_move_exec_tb_top
`default_nettype wire
